// ---- sim/dsp_peer.sv ----
/*
 Remote serial node: sends frames on both channels' input lines
 and samples frames from the second channel's output line.
 Assumes the shared pclk; both lines idle high like a pulled-up pin.
*/
`timescale 1ns/1ps
`default_nettype none
module dsp_peer (
  input wire logic pclk,
  input wire logic ser1_txd,
  input wire logic ser2_txd,
  output logic ser1_rxd_i,
  output logic ser2_rxd
);
  initial begin
    ser1_rxd_i = 1'b1;
    ser2_rxd = 1'b1;
  end
  // start zero, data lsb first, optional ninth, stop
  task automatic send_frame(input logic [7:0] d, input logic nin,
      input bit nine, input logic stop, input int bclk);
    logic [10:0] f;
    int n;
    f = nine ? {stop, nin, d, 1'b0} : {1'b0, stop, d, 1'b0};
    n = nine ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      ser2_rxd <= f[i];
      ser1_rxd_i <= f[i];
      repeat (bclk - 1) @(posedge pclk);
    end
    @(posedge pclk);
    ser2_rxd <= 1'b1;
    ser1_rxd_i <= 1'b1;
  endtask
  // short low blip, gone before the vote states
  task automatic glitch(input int len);
    @(posedge pclk);
    ser2_rxd <= 1'b0;
    ser1_rxd_i <= 1'b0;
    repeat (len) @(posedge pclk);
    ser2_rxd <= 1'b1;
    ser1_rxd_i <= 1'b1;
  endtask
  task automatic wait_fall(input int ch);
    int k;
    k = 0;
    while (((ch == 1 ? ser1_txd : ser2_txd) !== 1'b0) && k < 3000) begin
      @(posedge pclk);
      k++;
    end
  endtask
  // sample mid-bit from the falling start edge
  task automatic recv_frame(input int n, input int bclk,
      output logic [10:0] f);
    f = '0;
    wait_fall(2);
    repeat (bclk / 2) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      f[i] = ser2_txd;
      repeat (bclk) @(posedge pclk);
    end
  endtask
  task automatic low_len(input int ch, output int len);
    len = 0;
    wait_fall(ch);
    while ((ch == 1 ? ser1_txd : ser2_txd) === 1'b0 && len < 3000) begin
      @(posedge pclk);
      len++;
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/test_dual_async_serial_port.sv ----
/*
 Self-checking bench: APB master, timer tick source, remote node.
 Assumes both timer ticks every 4 clocks, so one bit is 64 clocks.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) chk(32'(a), 32'(e))
module test_dual_async_serial_port;
  import dsp_pkg::*;
  localparam int BCLK = 64;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata;
  logic baud_tmr_ovf, ch2_tmr_ovf, ser1_rxd_i, ser2_rxd;
  logic ser1_txd, ser2_txd, ser1_oe;
  logic [1:0] tick_cnt;
  int error_cnt, num_checks, cycles;
  dsp_serial_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .baud_tmr_ovf(baud_tmr_ovf), .ch2_tmr_ovf(ch2_tmr_ovf),
    .ser1_rxd_i(ser1_rxd_i), .ser1_rxd_o(), .ser1_rxd_oe(ser1_oe),
    .ser1_txd(ser1_txd), .ser2_rxd(ser2_rxd), .ser2_txd(ser2_txd));
  dsp_peer peer (.pclk(pclk), .ser1_txd(ser1_txd), .ser2_txd(ser2_txd),
    .ser1_rxd_i(ser1_rxd_i), .ser2_rxd(ser2_rxd));
  initial pclk = 1'b0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) begin
    tick_cnt <= tick_cnt + 2'd1;
    baud_tmr_ovf <= (tick_cnt == 2'd3);
    ch2_tmr_ovf <= (tick_cnt == 2'd3);
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] a, input logic [31:0] e);
    num_checks++;
    if (a !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, a, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic err);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t no ready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {24'h0, d}, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic rx2(input logic [7:0] d, input logic nin, input bit nine,
      input logic stop);
    peer.send_frame(d, nin, nine, stop, BCLK);
    repeat (8) @(posedge pclk);
  endtask
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    rd(CFG_OFS, r);
    `CHK(r, 32'h0);
    rd(BUF_OFS, r);
    `CHK(r, 32'h0);
    wr(CFG_OFS, 8'hFF);
    rd(CFG_OFS, r);
    `CHK(r, 32'hA7);
    wr(SLAVE_MATCH_ADDRESS_OFS, 8'h5A);
    wr(SMASK_OFS, 8'hC3);
    rd(SLAVE_MATCH_ADDRESS_OFS, r);
    `CHK(r, 32'h5A);
    rd(SMASK_OFS, r);
    `CHK(r, 32'hC3);
    apb(1'b1, 8'h40, 32'hFF, r, e);
    `CHK(e, 1'b1);
    wr(CFG_OFS, 8'h00);
    $display("test regs done");
  endtask
  // low time of the first pulse per mode and speed bit
  task automatic t_rates();
    logic [7:0] cfg [5] = '{8'h04, 8'h84, 8'h02, 8'h00, 8'h20};
    int exp_len [5] = '{64, 32, 64, 6, 1};
    int len;
    for (int i = 0; i < 5; i++) begin
      wr(CFG_OFS, cfg[i]);
      wr(BUF_OFS, 8'h01);
      peer.low_len(1, len);
      `CHK(len, exp_len[i]);
      `CHK(ser1_oe, i >= 3);
      repeat (800) @(posedge pclk);
    end
    $display("test rates done");
  endtask
  task automatic t_tx();
    logic [10:0] f;
    logic [31:0] r;
    wr(CTL2_OFS, 8'h00);
    wr(BUF2_OFS, 8'hA5);
    peer.recv_frame(10, BCLK, f);
    `CHK(f[9:0], {1'b1, 8'hA5, 1'b0});
    rd(CTL2_OFS, r);
    `CHK(r[1], 1'b1);
    repeat (BCLK) @(posedge pclk);
    wr(CTL2_OFS, 8'h28);
    wr(BUF2_OFS, 8'h3C);
    peer.recv_frame(11, BCLK, f);
    `CHK(f, {2'b11, 8'h3C, 1'b0});
    rd(CTL2_OFS, r);
    `CHK(r[1], 1'b1);
    repeat (BCLK) @(posedge pclk);
    wr(CTL2_OFS, 8'h20);
    $display("test tx done");
  endtask
  task automatic t_rx8();
    logic [31:0] r;
    wr(CTL2_OFS, 8'h10);
    peer.glitch(BCLK / 4);
    // idle so the blip is voted out before the real start edge
    repeat (BCLK) @(posedge pclk);
    rx2(8'hC3, 1'b0, 0, 1'b1);
    rd(BUF2_OFS, r);
    `CHK(r, 32'hC3);
    rd(CTL2_OFS, r);
    `CHK(r[2:0], 3'b101);
    rx2(8'h11, 1'b0, 0, 1'b1);
    rd(BUF2_OFS, r);
    `CHK(r, 32'hC3);
    // software clears the flag before the next frame
    wr(CTL2_OFS, 8'h50);
    rx2(8'h77, 1'b0, 0, 1'b0);
    rd(CTL2_OFS, r);
    `CHK(r[0], 1'b0);
    wr(CTL2_OFS, 8'h10);
    rx2(8'h66, 1'b0, 0, 1'b0);
    rd(CTL2_OFS, r);
    `CHK(r[2:0], 3'b001);
    wr(CTL2_OFS, 8'h70);
    $display("test rx8 done");
  endtask
  task automatic t_rx9();
    logic [31:0] r;
    rx2(8'h12, 1'b0, 1, 1'b1);
    rd(CTL2_OFS, r);
    `CHK(r[0], 1'b0);
    rx2(8'h34, 1'b1, 1, 1'b1);
    rd(CTL2_OFS, r);
    `CHK(r[2:0], 3'b101);
    rd(BUF2_OFS, r);
    `CHK(r, 32'h34);
    wr(CTL2_OFS, 8'h30);
    rx2(8'h56, 1'b0, 1, 1'b0);
    rd(CTL2_OFS, r);
    `CHK(r[0], 1'b0);
    rx2(8'h9A, 1'b0, 1, 1'b1);
    rd(CTL2_OFS, r);
    `CHK(r[2:0], 3'b001);
    rd(BUF2_OFS, r);
    `CHK(r, 32'h9A);
    $display("test rx9 done");
  endtask
  task automatic t_rx1();
    logic [31:0] r;
    wr(CTL2_OFS, 8'h00);
    wr(CFG_OFS, 8'h07);
    wr(SLAVE_MATCH_ADDRESS_OFS, 8'hA4);
    wr(SMASK_OFS, 8'hFA);
    wr(CTL_OFS, 8'h10);
    rx2(8'hA1, 1'b1, 1, 1'b1);
    rd(BUF_OFS, r);
    `CHK(r, 32'hA1);
    wr(CTL_OFS, 8'h10);
    rx2(8'hB1, 1'b1, 1, 1'b1);
    rd(CTL_OFS, r);
    `CHK(r[0], 1'b0);
    rx2(8'hFE, 1'b1, 1, 1'b1);
    rd(BUF_OFS, r);
    `CHK(r, 32'hFE);
    $display("test rx1 done");
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    tick_cnt = 2'd0;
    baud_tmr_ovf = 1'b0;
    ch2_tmr_ovf = 1'b0;
    error_cnt = 0;
    num_checks = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_rates();
    t_tx();
    t_rx8();
    t_rx9();
    t_rx1();
    finish_test();
  end
endmodule
`default_nettype wire

// ---- src/dsp_pkg.sv ----
/*
 Constants for the two-channel serial port: register offsets, field
 positions, reset values and divider counts. Assumes a 32-bit APB host.
*/
// What this block does
// - Fixed 9-bit mode baud is clock/64, or clock/32 with doubling.
// - Shift mode clocks data at clock/12, or clock/2 when fast.
// - Reserved mode-config bits read zero and ignore writes.
// - Mode field bits 2-1: shift, 8-bit var, 9-bit fixed, 9-bit var.
// - Variable-rate modes run at baud timer overflow rate over 16.
// - 8-bit mode with check set flags receive only on stop bit one.
// - 9-bit modes with check set flag receive only on ninth bit one.
// - Buffer write gives transmit byte; read returns last received byte.
// - Address match compares only bits whose mask bit is one.
// - Broadcast is address OR mask; zero bits are don't-care.
// - Second channel: two modes, no error flags, no address match.
// - 8-bit frame: start zero, eight data LSB first, stop one.
// - Buffer write starts sending at next divide-by-16 rollover.
// - Transmit flag sets as the stop bit starts in 8-bit mode.
// - Receive needs enable; falling input edge resets the 16 counter.
// - Bit value is majority of samples at states 7, 8 and 9.
// - A start bit voted one is dropped and the receiver rearms.
// - 8-bit frame loads byte and stop bit only if flag clear.
// - 9-bit frame: start, eight data LSB first, ninth bit, stop.
// - 9-bit send copies ninth bit in; flag sets as stop starts.
// - 9-bit receive stores ninth bit and byte; flag needs stop one.
package dsp_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] CFG_OFS = 8'h00;
  localparam logic [7:0] BUF_OFS = 8'h04;
  localparam logic [7:0] SLAVE_MATCH_ADDRESS_OFS = 8'h08;
  localparam logic [7:0] SMASK_OFS = 8'h0C;
  localparam logic [7:0] CTL_OFS = 8'h10;
  localparam logic [7:0] BUF2_OFS = 8'h14;
  localparam logic [7:0] CTL2_OFS = 8'h18;
  localparam int CFG_DBL_BIT = 7;
  localparam int CFG_SPD_BIT = 5;
  localparam int CFG_MODE_LSB = 1;
  localparam int CFG_MPC_BIT = 0;
  localparam int CTL_MPC_BIT = 6;
  localparam int CTL_MODE9_BIT = 5;
  localparam int CTL_REN_BIT = 4;
  localparam int CTL_TB8_BIT = 3;
  localparam int CTL_RB8_BIT = 2;
  localparam int CTL_TI_BIT = 1;
  localparam int CTL_RI_BIT = 0;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [2:0] M2_OS_DIV_NORM = 3'h4;
  localparam logic [2:0] M2_OS_DIV_DBL = 3'h2;
  localparam logic [2:0] M0_HALF_SLOW = 3'h6;
  localparam logic [2:0] M0_HALF_FAST = 3'h1;
  localparam logic [3:0] VOTE_A = 4'h7;
  localparam logic [3:0] VOTE_B = 4'h8;
  localparam logic [3:0] VOTE_C = 4'h9;
  localparam logic [3:0] BITS_SHIFT = 4'h8;
  localparam logic [3:0] FRAME8_LEN = 4'hA;
  localparam logic [3:0] FRAME9_LEN = 4'hB;
  typedef enum logic [1:0] {
    MODE_SHIFT, MODE_8VAR, MODE_9FIX, MODE_9VAR
  } dsp_mode_type;
endpackage

// ---- src/dsp_serial_port.sv ----
/*
 Two-channel serial port: one channel engine per channel plus the APB
 register file. Assumes timer overflow pulses on the same clock.
*/
// Design decisions made here: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module dsp_chan import dsp_pkg::*; #(
  parameter bit ADDR_MATCH = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire dsp_mode_type mode,
  input wire logic mpc,
  input wire logic ren,
  input wire logic tb8,
  input wire logic [7:0] slave_match_address,
  input wire logic [7:0] smask,
  input wire logic os_tick,
  input wire logic half_tick,
  input wire logic wr,
  input wire logic [7:0] wdata,
  input wire logic clr_ti,
  input wire logic clr_ri,
  input wire logic rxd_i,
  output logic txd,
  output logic dat_o,
  output logic dat_oe,
  output logic ti,
  output logic ri,
  output logic rb8,
  output logic [7:0] rbuf
);
  typedef struct packed {
    logic s1, s2, s3, lvl, smp;
    logic tx_busy, m0_rx, m0_ph;
    logic [3:0] tx_cnt, tx_left;
    logic [10:0] tx_sh;
    logic txd, dat, dat_oe, ti, ri, rb8;
    logic [7:0] rbuf;
    logic rx_busy;
    logic [3:0] rx_cnt, rx_bitn;
    logic [8:0] rx_sh;
    logic v7, v8;
  } dsp_chan_state_type;
  localparam dsp_chan_state_type CHAN_RST = '{s1: 1'b1, s2: 1'b1,
    s3: 1'b1, lvl: 1'b1, smp: 1'b1, txd: 1'b1, dat: 1'b1, default: '0};

  dsp_chan_state_type q, n;
  logic nine, tx_roll, rx_on, rx_decide, vote, match, stop, ninth;
  logic [3:0] rx_cur, rx_last;
  logic [7:0] rx_byte, bcast;

  always_comb begin
    n = q;
    nine = mode == MODE_9FIX || mode == MODE_9VAR;
    tx_roll = os_tick && q.tx_cnt == 4'hF;
    rx_on = ren && mode != MODE_SHIFT;
    rx_cur = q.rx_cnt + 4'h1;
    rx_last = nine ? FRAME9_LEN - 4'h1 : FRAME8_LEN - 4'h1;
    rx_decide = rx_on && os_tick && q.rx_busy && rx_cur == VOTE_C;
    vote = (q.v7 & q.v8) | (q.v7 & q.lvl) | (q.v8 & q.lvl);
    stop = vote;
    ninth = q.rx_sh[8];
    rx_byte = q.rx_sh[7:0];
    bcast = slave_match_address | smask;
    match = !ADDR_MATCH
      || ((rx_byte ^ slave_match_address) & smask) == 8'h00
      || (rx_byte & bcast) == bcast;
    // third stage compared against second; first feeds only the second
    n.s1 = rxd_i;
    n.s2 = q.s1;
    n.s3 = q.s2;
    if (q.s2 == q.s3) begin
      n.lvl = q.s3;
    end
    // clear first so that a same-cycle hardware set wins
    if (clr_ti) begin
      n.ti = 1'b0;
    end
    if (clr_ri) begin
      n.ri = 1'b0;
    end
    if (os_tick) begin
      n.tx_cnt = q.tx_cnt + 4'h1;
    end
    if (mode == MODE_SHIFT) begin
      if (!q.tx_busy && wr) begin
        n.tx_busy = 1'b1;
        n.m0_rx = 1'b0;
        n.tx_sh = {3'h7, wdata};
        n.tx_left = BITS_SHIFT;
        n.m0_ph = 1'b0;
        n.dat_oe = 1'b1;
      end else if (!q.tx_busy && ren && !q.ri) begin
        n.tx_busy = 1'b1;
        n.m0_rx = 1'b1;
        n.tx_left = BITS_SHIFT;
        n.m0_ph = 1'b0;
        n.dat_oe = 1'b0;
      end else if (q.tx_busy && half_tick) begin
        if (!q.m0_ph) begin
          n.txd = 1'b0;
          n.dat = q.tx_sh[0];
          n.m0_ph = 1'b1;
        end else begin
          n.txd = 1'b1;
          n.m0_ph = 1'b0;
          n.tx_sh = {q.tx_sh[10:8], q.m0_rx ? q.lvl : 1'b1, q.tx_sh[7:1]};
          n.tx_left = q.tx_left - 4'h1;
          if (q.tx_left == 4'h1) begin
            n.tx_busy = 1'b0;
            n.dat_oe = 1'b0;
            if (q.m0_rx) begin
              n.rbuf = {q.lvl, q.tx_sh[7:1]};
              n.ri = 1'b1;
            end else begin
              n.ti = 1'b1;
            end
          end
        end
      end
    end else begin
      n.dat_oe = 1'b0;
      if (!q.tx_busy && wr) begin
        n.tx_busy = 1'b1;
        n.m0_rx = 1'b0;
        // idle until rollover; bit timing ignores the write instant
        n.tx_sh = {1'b1, nine ? tb8 : 1'b1, wdata, 1'b0};
        n.tx_left = nine ? FRAME9_LEN : FRAME8_LEN;
      end else if (q.tx_busy && tx_roll) begin
        if (q.tx_left == 4'h0) begin
          n.tx_busy = 1'b0;
        end else begin
          n.txd = q.tx_sh[0];
          n.tx_sh = {1'b1, q.tx_sh[10:1]};
          n.tx_left = q.tx_left - 4'h1;
          if (q.tx_left == 4'h1) begin
            n.ti = 1'b1;
          end
        end
      end
    end
    if (!rx_on) begin
      n.rx_busy = 1'b0;
    end else if (os_tick) begin
      n.smp = q.lvl;
      if (!q.rx_busy) begin
        if (q.smp && !q.lvl) begin
          n.rx_busy = 1'b1;
          n.rx_cnt = 4'h0;
          n.rx_bitn = 4'h0;
        end
      end else begin
        n.rx_cnt = rx_cur;
        if (rx_cur == VOTE_A) begin
          n.v7 = q.lvl;
        end
        if (rx_cur == VOTE_B) begin
          n.v8 = q.lvl;
        end
        if (rx_decide) begin
          n.rx_bitn = q.rx_bitn + 4'h1;
          if (q.rx_bitn == 4'h0) begin
            if (vote) begin
              n.rx_busy = 1'b0;
            end
          end else if (q.rx_bitn == rx_last) begin
            n.rx_busy = 1'b0;
            if (!q.ri) begin
              if (!nine) begin
                if (!mpc || stop) begin
                  n.rbuf = rx_byte;
                  n.rb8 = stop;
                  n.ri = 1'b1;
                end
              end else if (!mpc) begin
                n.rbuf = rx_byte;
                n.rb8 = ninth;
                n.ri = stop;
              end else if (ninth && stop && match) begin
                n.rbuf = rx_byte;
                n.rb8 = ninth;
                n.ri = 1'b1;
              end
            end
          end else begin
            n.rx_sh[q.rx_bitn - 4'h1] = vote;
          end
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= CHAN_RST;
    end else begin
      q <= n;
    end
  end

  assign txd = q.txd;
  assign dat_o = q.dat;
  assign dat_oe = q.dat_oe;
  assign ti = q.ti;
  assign ri = q.ri;
  assign rb8 = q.rb8;
  assign rbuf = q.rbuf;

  chk_tx_rollover: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(q.txd) && mode != MODE_SHIFT |-> $past(tx_roll))
    else $error("start bit not on counter rollover");
  chk_tx_stop_flag: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.ti) && mode != MODE_SHIFT |-> q.txd && $past(tx_roll))
    else $error("transmit flag not at stop bit start");
  chk_tx_ninth: assert property (@(posedge pclk) disable iff (!presetn)
    !q.tx_busy && wr && nine && mode != MODE_SHIFT
    |=> q.tx_sh[9] == $past(tb8))
    else $error("ninth bit not loaded");
  chk_rx_enable: assert property (@(posedge pclk) disable iff (!presetn)
    !ren |=> !q.rx_busy)
    else $error("receiver busy while disabled");
  chk_rx_align: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.rx_busy) |-> q.rx_cnt == 4'h0 && $past(os_tick))
    else $error("counter not reset on start edge");
  chk_start_reject: assert property (@(posedge pclk) disable iff (!presetn)
    rx_decide && q.rx_bitn == 4'h0 && vote |=> !q.rx_busy)
    else $error("bad start bit accepted");
  chk_rx_hold: assert property (@(posedge pclk) disable iff (!presetn)
    q.ri && !clr_ri |=> q.ri && $stable(q.rbuf))
    else $error("buffer changed while flag set");
  chk_mpc_ninth: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.ri) && nine && mpc |-> q.rb8)
    else $error("data byte flagged under check");
  chk_vote_state: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(q.ri) && mode != MODE_SHIFT |-> $past(rx_cur) == VOTE_C)
    else $error("frame ended off the vote state");
endmodule

module dsp_serial_port import dsp_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic baud_tmr_ovf,
  input wire logic ch2_tmr_ovf,
  input wire logic ser1_rxd_i,
  output logic ser1_rxd_o,
  output logic ser1_rxd_oe,
  output logic ser1_txd,
  input wire logic ser2_rxd,
  output logic ser2_txd
);
  typedef struct packed {
    logic dbl, spd;
    logic [1:0] mode;
    logic mpc;
    logic [7:0] slave_match_address, smask;
    logic ren1, tb81, ren2, tb82, mode9, mpc2;
    logic [31:0] prdata;
    logic [2:0] m2_cnt, m0_cnt;
  } dsp_top_state_type;

  function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] a);
    if (a == CFG_OFS) begin
      reg_index = 3'h0;
    end else if (a == BUF_OFS) begin
      reg_index = 3'h1;
    end else if (a == SLAVE_MATCH_ADDRESS_OFS) begin
      reg_index = 3'h2;
    end else if (a == SMASK_OFS) begin
      reg_index = 3'h3;
    end else if (a == CTL_OFS) begin
      reg_index = 3'h4;
    end else if (a == BUF2_OFS) begin
      reg_index = 3'h5;
    end else if (a == CTL2_OFS) begin
      reg_index = 3'h6;
    end else begin
      reg_index = 3'h7;
    end
  endfunction

  dsp_top_state_type q, n;
  logic wr, cfg_wr, m2_tick, m0_tick, os1;
  logic [2:0] widx, m2_lim, m0_lim;
  logic [7:0] rd8;
  logic ti1, ri1, rb81, ti2, ri2, rb82;
  logic [7:0] rbuf1, rbuf2;
  dsp_mode_type mode1, mode2;

  always_comb begin
    n = q;
    wr = psel && penable && pwrite;
    widx = reg_index(paddr);
    cfg_wr = wr && widx == 3'h0;
    mode1 = dsp_mode_type'(q.mode);
    mode2 = q.mode9 ? MODE_9VAR : MODE_8VAR;
    m2_lim = q.dbl ? M2_OS_DIV_DBL : M2_OS_DIV_NORM;
    m0_lim = q.spd ? M0_HALF_FAST : M0_HALF_SLOW;
    m2_tick = q.m2_cnt == m2_lim - 3'h1;
    m0_tick = q.m0_cnt == m0_lim - 3'h1;
    os1 = mode1 == MODE_9FIX ? m2_tick : baud_tmr_ovf;
    // dividers restart on a config write so a new rate starts clean
    n.m2_cnt = (m2_tick || cfg_wr) ? 3'h0 : q.m2_cnt + 3'h1;
    n.m0_cnt = (m0_tick || cfg_wr) ? 3'h0 : q.m0_cnt + 3'h1;
    rd8 = 8'h00;
    if (widx == 3'h0) begin
      rd8[CFG_DBL_BIT] = q.dbl;
      rd8[CFG_SPD_BIT] = q.spd;
      rd8[CFG_MODE_LSB+:2] = q.mode;
      rd8[CFG_MPC_BIT] = q.mpc;
    end else if (widx == 3'h1) begin
      rd8 = rbuf1;
    end else if (widx == 3'h2) begin
      rd8 = q.slave_match_address;
    end else if (widx == 3'h3) begin
      rd8 = q.smask;
    end else if (widx == 3'h4) begin
      rd8 = {3'h0, q.ren1, q.tb81, rb81, ti1, ri1};
    end else if (widx == 3'h5) begin
      rd8 = rbuf2;
    end else if (widx == 3'h6) begin
      rd8 = {1'b0, q.mpc2, q.mode9, q.ren2, q.tb82, rb82, ti2, ri2};
    end
    // read data is captured in the setup cycle, ready in the access cycle
    if (psel && !penable && !pwrite) begin
      n.prdata = {24'h000000, rd8};
    end
    if (wr) begin
      if (widx == 3'h0) begin
        n.dbl = pwdata[CFG_DBL_BIT];
        n.spd = pwdata[CFG_SPD_BIT];
        n.mode = pwdata[CFG_MODE_LSB+:2];
        n.mpc = pwdata[CFG_MPC_BIT];
      end else if (widx == 3'h2) begin
        n.slave_match_address = pwdata[7:0];
      end else if (widx == 3'h3) begin
        n.smask = pwdata[7:0];
      end else if (widx == 3'h4) begin
        n.ren1 = pwdata[CTL_REN_BIT];
        n.tb81 = pwdata[CTL_TB8_BIT];
      end else if (widx == 3'h6) begin
        n.ren2 = pwdata[CTL_REN_BIT];
        n.tb82 = pwdata[CTL_TB8_BIT];
        n.mode9 = pwdata[CTL_MODE9_BIT];
        n.mpc2 = pwdata[CTL_MPC_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && widx == 3'h7;

  dsp_chan #(.ADDR_MATCH(1'b1)) u_ch1 (
    .pclk(pclk), .presetn(presetn), .mode(mode1), .mpc(q.mpc),
    .ren(q.ren1), .tb8(q.tb81), .slave_match_address(q.slave_match_address), .smask(q.smask),
    .os_tick(os1), .half_tick(m0_tick),
    .wr(wr && widx == 3'h1), .wdata(pwdata[7:0]),
    .clr_ti(wr && widx == 3'h4 && !pwdata[CTL_TI_BIT]),
    .clr_ri(wr && widx == 3'h4 && !pwdata[CTL_RI_BIT]),
    .rxd_i(ser1_rxd_i), .txd(ser1_txd), .dat_o(ser1_rxd_o),
    .dat_oe(ser1_rxd_oe), .ti(ti1), .ri(ri1), .rb8(rb81), .rbuf(rbuf1)
  );

  dsp_chan #(.ADDR_MATCH(1'b0)) u_ch2 (
    .pclk(pclk), .presetn(presetn), .mode(mode2), .mpc(q.mpc2),
    .ren(q.ren2), .tb8(q.tb82), .slave_match_address(8'h00), .smask(8'h00),
    .os_tick(ch2_tmr_ovf), .half_tick(1'b0),
    .wr(wr && widx == 3'h5), .wdata(pwdata[7:0]),
    .clr_ti(wr && widx == 3'h6 && !pwdata[CTL_TI_BIT]),
    .clr_ri(wr && widx == 3'h6 && !pwdata[CTL_RI_BIT]),
    .rxd_i(ser2_rxd), .txd(ser2_txd), .dat_o(), .dat_oe(),
    .ti(ti2), .ri(ri2), .rb8(rb82), .rbuf(rbuf2)
  );

  chk_cfg_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && paddr == CFG_OFS
    |-> prdata[6] == 1'b0 && prdata[4:3] == 2'h0)
    else $error("reserved config bits read nonzero");
  chk_m2_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (m2_tick && !q.dbl) ##1 (!cfg_wr)[*4] |-> m2_tick
    && $past(m2_tick, 1) == 1'b0 && $past(m2_tick, 3) == 1'b0)
    else $error("fixed-rate oversample period wrong");
  chk_m0_rate: assert property (@(posedge pclk) disable iff (!presetn)
    (m0_tick && !q.spd && !cfg_wr) ##1 (!cfg_wr)[*6] |-> m0_tick
    && $past(m0_tick, 1) == 1'b0 && $past(m0_tick, 5) == 1'b0)
    else $error("shift clock half period wrong");
endmodule
`default_nettype wire
